// File: core/phy_vendor_config_irq_regs.sv
// Vendor configuration, powerdown test and change-interrupt registers
`timescale 1ns/10ps
module phy_vendor_config_irq_regs
    import phy_vendor_regs_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire regReq_s regReq,
    output logic [DATA_W-1:0] regRdData,
    output logic regRdValid,
    output logic regHit,
    input wire logic serialStrap,
    input wire linkState_s linkState,
    input wire logic loopback10,
    input wire logic polarityReversed,
    input wire logic autoMdix,
    input wire logic rawSignalDetect,
    input wire logic [PD_SEL_W-1:0] normalPowerdown,
    output logic linkPulseTxEn,
    output logic forceLinkGood,
    output logic heartbeatActive,
    output logic jabberActive,
    output logic squelchNormal,
    output logic serialIfActive,
    output logic signalDetect100,
    output logic crossoverState,
    output logic negotiationLoopback,
    output logic [PD_SEL_W-1:0] sectionPowerdown,
    output logic irq_out_n
);

    function automatic logic addrIs(
        input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] target
    );
        return addr == target;
    endfunction

    function automatic logic [DATA_W-1:0] maskedWrite(
        input logic [DATA_W-1:0] old,
        input logic [DATA_W-1:0] data,
        input logic [DATA_W-1:0] wrMask
    );
        return (old & ~wrMask) | (data & wrMask);
    endfunction

    // Stored registers
    logic [DATA_W-1:0] tenBase_ff;
    logic [DATA_W-1:0] pwrdn_ff;
    logic [DATA_W-1:0] vendor_ff;
    logic [DATA_W-1:0] irqCtl_ff;
    logic polarity_ff;
    logic strapDone_ff;
    logic irqOutN_ff;
    logic [DATA_W-1:0] rdData_ff;
    logic rdValid_ff;

    logic [DATA_W-1:0] nxt_tenBase;
    logic [DATA_W-1:0] nxt_pwrdn;
    logic [DATA_W-1:0] nxt_vendor;
    logic [DATA_W-1:0] nxt_irqCtl;
    logic [DATA_W-1:0] nxt_rdData;
    logic [DATA_W-1:0] tenBaseBase;

    // Address decode
    logic hitTen;
    logic hitPd;
    logic hitVc;
    logic hitIrq;
    logic wrTake;
    logic rdTake;
    logic irqReadClr;

    assign hitTen = addrIs(regReq.addr, ADDR_TEN_BASE);
    assign hitPd = addrIs(regReq.addr, ADDR_PWRDN);
    assign hitVc = addrIs(regReq.addr, ADDR_VENDOR);
    assign hitIrq = addrIs(regReq.addr, ADDR_IRQ);
    assign regHit = hitTen | hitPd | hitVc | hitIrq;
    assign wrTake = clkEn & regReq.wrEn;
    assign rdTake = clkEn & regReq.rdEn;
    assign irqReadClr = rdTake & hitIrq;

    // Strap sets serial select at first cycle after reset
    assign tenBaseBase = strapDone_ff ? tenBase_ff :
        ((tenBase_ff & ~(ZERO_WORD | (16'h0001 << TB_SERIAL))) |
         ({{(DATA_W-1){1'b0}}, serialStrap} << TB_SERIAL));

    assign nxt_tenBase = (wrTake & hitTen) ?
        maskedWrite(tenBaseBase, regReq.wrData, TEN_BASE_WR_MASK) :
        tenBaseBase;
    assign nxt_pwrdn = (wrTake & hitPd) ?
        maskedWrite(pwrdn_ff, regReq.wrData, PWRDN_WR_MASK) : pwrdn_ff;
    assign nxt_vendor = (wrTake & hitVc) ?
        maskedWrite(vendor_ff, regReq.wrData, VENDOR_WR_MASK) : vendor_ff;
    // Link mask sits at bit nine
    assign nxt_irqCtl = (wrTake & hitIrq) ?
        maskedWrite(irqCtl_ff, regReq.wrData, IRQ_WR_MASK) : irqCtl_ff;

    // Link status changes
    logic [NUM_EVT-1:0] evtLevel;
    logic [NUM_EVT-1:0] evtChanged;
    logic [NUM_EVT-1:0] evtMask;
    logic irqStatus;

    assign evtLevel = linkState;
    assign evtMask[EVT_LINK] = irqCtl_ff[IRQ_LINK_MASK];
    assign evtMask[EVT_SPEED] = irqCtl_ff[IRQ_SPEED_MASK];
    assign evtMask[EVT_DUPLEX] = irqCtl_ff[IRQ_DUPLEX_MASK];

    genvar gi;
    generate
        for (gi = 0; gi < NUM_EVT; gi++) begin : gEvt
            change_latch uLatch (
                .core_clk(core_clk),
                .rst(rst),
                .clkEn(clkEn),
                .level(evtLevel[gi]),
                .clearRd(irqReadClr),
                .changed(evtChanged[gi])
            );
        end
    endgenerate

    assign irqStatus = ~irqCtl_ff[IRQ_MASTER_MASK] &
        (|(evtChanged & ~evtMask));

    // Readback words
    logic [DATA_W-1:0] tenBaseRd;
    logic [DATA_W-1:0] vendorRd;
    logic [DATA_W-1:0] irqRd;

    assign tenBaseRd = (tenBase_ff & TEN_BASE_WR_MASK) |
        ({{(DATA_W-1){1'b0}}, polarity_ff} << TB_POLARITY);
    assign vendorRd = (vendor_ff & VENDOR_WR_MASK) |
        ({{(DATA_W-1){1'b0}}, crossoverState} << VC_XOVER_STATE);
    assign irqRd = (irqCtl_ff & IRQ_WR_MASK) |
        ({{(DATA_W-1){1'b0}}, irqStatus} << IRQ_PENDING) |
        ({{(DATA_W-1){1'b0}}, evtChanged[EVT_DUPLEX]} << IRQ_DUPLEX_CHG) |
        ({{(DATA_W-1){1'b0}}, evtChanged[EVT_SPEED]} << IRQ_SPEED_CHG) |
        ({{(DATA_W-1){1'b0}}, evtChanged[EVT_LINK]} << IRQ_LINK_CHG) |
        ({{(DATA_W-1){1'b0}}, irqStatus} << IRQ_STATUS);

    // Unmapped and reserved read as zero
    assign nxt_rdData = hitTen ? tenBaseRd :
        hitPd ? (pwrdn_ff & PWRDN_WR_MASK) :
        hitVc ? vendorRd :
        hitIrq ? irqRd : ZERO_WORD;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tenBase_ff <= TEN_BASE_RST;
            pwrdn_ff <= PWRDN_RST;
            vendor_ff <= VENDOR_RST;
            irqCtl_ff <= IRQ_RST;
            strapDone_ff <= 1'b0;
        end else if (clkEn) begin
            tenBase_ff <= nxt_tenBase;
            pwrdn_ff <= nxt_pwrdn;
            vendor_ff <= nxt_vendor;
            irqCtl_ff <= nxt_irqCtl;
            strapDone_ff <= 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            polarity_ff <= 1'b0;
            irqOutN_ff <= 1'b1;
        end else if (clkEn) begin
            polarity_ff <= polarityReversed;
            irqOutN_ff <= ~irqStatus;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdData_ff <= ZERO_WORD;
            rdValid_ff <= 1'b0;
        end else if (clkEn) begin
            rdValid_ff <= regReq.rdEn;
            if (regReq.rdEn) begin
                rdData_ff <= nxt_rdData;
            end
        end
    end

    assign regRdData = rdData_ff;
    assign regRdValid = rdValid_ff;
    assign irq_out_n = irqOutN_ff;

    // Mode controls toward the transceiver
    logic tenMode;
    logic jabberCtlMode;

    assign tenMode = ~linkState.speed100;
    // Link pulse control only at 10M
    assign linkPulseTxEn = tenMode & tenBase_ff[TB_LINK_PULSE];
    assign forceLinkGood = tenMode & ~tenBase_ff[TB_LINK_PULSE];
    assign heartbeatActive = tenBase_ff[TB_HEARTBEAT] &
        ~linkState.fullDuplex;
    // Jabber bit acts in listed modes
    assign jabberCtlMode = tenMode & (linkState.fullDuplex | loopback10);
    assign jabberActive = jabberCtlMode ? tenBase_ff[TB_JABBER] : 1'b1;
    assign squelchNormal = tenBase_ff[TB_SQUELCH];
    assign serialIfActive = tenMode & tenBase_ff[TB_SERIAL];
    assign signalDetect100 = vendor_ff[VC_FORCE_DETECT] | rawSignalDetect;
    assign crossoverState = vendor_ff[VC_XOVER_MANUAL] ?
        vendor_ff[VC_XOVER_FIX] : autoMdix;
    assign negotiationLoopback = vendor_ff[VC_NEG_LOOP];

    generate
        for (gi = 0; gi < PD_SEL_W; gi++) begin : gPd
            assign sectionPowerdown[gi] = pwrdn_ff[gi] ?
                vendor_ff[VC_POWERDOWN_VALUE] : normalPowerdown[gi];
        end
    endgenerate

endmodule

// File: core/phy_vendor_regs_pkg.sv
// Constants, field layout and carriers for the vendor register bank
package phy_vendor_regs_pkg;

    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;

    // Management register addresses
    localparam logic [ADDR_W-1:0] ADDR_TEN_BASE = 5'h12;
    localparam logic [ADDR_W-1:0] ADDR_PWRDN = 5'h13;
    localparam logic [ADDR_W-1:0] ADDR_VENDOR = 5'h14;
    localparam logic [ADDR_W-1:0] ADDR_IRQ = 5'h15;

    // ten_base_config_status fields
    localparam int TB_LINK_PULSE = 14;
    localparam int TB_HEARTBEAT = 13;
    localparam int TB_SQUELCH = 12;
    localparam int TB_JABBER = 11;
    localparam int TB_SERIAL = 10;
    localparam int TB_POLARITY = 0;

    // powerdown_test_control fields
    localparam int PD_SEL_W = 9;

    // vendor_config fields
    localparam int VC_FORCE_DETECT = 13;
    localparam int VC_XOVER_STATE = 7;
    localparam int VC_NEG_LOOP = 6;
    localparam int VC_XOVER_FIX = 5;
    localparam int VC_XOVER_MANUAL = 4;
    localparam int VC_POWERDOWN_VALUE = 0;

    // interrupt_control_status fields
    localparam int IRQ_PENDING = 15;
    localparam int IRQ_DUPLEX_MASK = 11;
    localparam int IRQ_SPEED_MASK = 10;
    localparam int IRQ_LINK_MASK = 9;
    localparam int IRQ_MASTER_MASK = 8;
    localparam int IRQ_DUPLEX_CHG = 4;
    localparam int IRQ_SPEED_CHG = 3;
    localparam int IRQ_LINK_CHG = 2;
    localparam int IRQ_STATUS = 0;

    // Change events, index order matches linkState_s packing
    localparam int NUM_EVT = 3;
    localparam int EVT_LINK = 0;
    localparam int EVT_SPEED = 1;
    localparam int EVT_DUPLEX = 2;

    // Writable bits per register; all others are reserved or read-only
    localparam logic [DATA_W-1:0] TEN_BASE_WR_MASK = 16'h7c00;
    localparam logic [DATA_W-1:0] PWRDN_WR_MASK = 16'h01ff;
    localparam logic [DATA_W-1:0] VENDOR_WR_MASK = 16'hf07f;
    localparam logic [DATA_W-1:0] IRQ_WR_MASK = 16'h0f00;

    // Reset values; serial select comes from the strap instead
    localparam logic [DATA_W-1:0] TEN_BASE_RST = 16'h7800;
    localparam logic [DATA_W-1:0] PWRDN_RST = 16'h0000;
    localparam logic [DATA_W-1:0] VENDOR_RST = 16'h0000;
    localparam logic [DATA_W-1:0] IRQ_RST = 16'h0f00;
    localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;

    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wrData;
    } regReq_s;

    typedef struct packed {
        logic fullDuplex;
        logic speed100;
        logic linkUp;
    } linkState_s;

endpackage

// File: core/change_latch.sv
// Sticky change detector for one status level, cleared by a read
`timescale 1ns/10ps
module change_latch (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic level,
    input wire logic clearRd,
    output logic changed
);

    logic prev_ff;
    logic primed_ff;
    logic changed_ff;
    logic evt;
    logic nxt_changed;

    // No event before the first sampled level
    assign evt = primed_ff & (level != prev_ff);
    // Set beats a clearing read in the same cycle
    assign nxt_changed = evt | (changed_ff & ~clearRd);
    assign changed = changed_ff;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prev_ff <= 1'b0;
            primed_ff <= 1'b0;
            changed_ff <= 1'b0;
        end else if (clkEn) begin
            prev_ff <= level;
            primed_ff <= 1'b1;
            changed_ff <= nxt_changed;
        end
    end

endmodule

// File: bench/phy_vendor_regs_sva.sv
// Port checker for the vendor register bank
`timescale 1ns/10ps
module phy_vendor_regs_sva
    import phy_vendor_regs_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire regReq_s regReq,
    input wire logic [DATA_W-1:0] regRdData,
    input wire logic regHit,
    input wire linkState_s linkState,
    input wire logic polarityReversed,
    input wire logic linkPulseTxEn,
    input wire logic serialIfActive,
    input wire logic crossoverState,
    input wire logic irq_out_n
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    wire rdOk = regReq.rdEn && clkEn;
    wire rdTen = rdOk && regReq.addr == ADDR_TEN_BASE;
    wire rdVen = rdOk && regReq.addr == ADDR_VENDOR;
    wire rdIrq = rdOk && regReq.addr == ADDR_IRQ;
    a_ten_reserved: assert property (
        rdTen |=> (regRdData & 16'h83fe) == 16'h0000)
        else $error("reserved ten base bits not zero");
    a_irq_reserved: assert property (
        rdIrq |=> (regRdData & 16'h70e2) == 16'h0000)
        else $error("reserved irq bits not zero");
    a_polarity_read: assert property (
        rdTen && $past(clkEn) && $stable(polarityReversed)
        |=> regRdData[TB_POLARITY] == $past(polarityReversed))
        else $error("polarity flag wrong");
    a_serial_read: assert property (
        rdTen && !linkState.speed100
        |=> regRdData[TB_SERIAL] == $past(serialIfActive))
        else $error("serial select and output differ");
    a_pulse_read: assert property (
        rdTen && !linkState.speed100
        |=> regRdData[TB_LINK_PULSE] == $past(linkPulseTxEn))
        else $error("link pulse bit and output differ");
    a_xover_read: assert property (
        rdVen |=> regRdData[VC_XOVER_STATE] == $past(crossoverState))
        else $error("crossover state bit wrong");
    a_pending_mirror: assert property (
        rdIrq |=> regRdData[IRQ_PENDING] == regRdData[IRQ_STATUS] &&
        regRdData[IRQ_STATUS] == !irq_out_n)
        else $error("pending differs from status or pin");
    a_hit_decode: assert property (
        regHit == (regReq.addr >= ADDR_TEN_BASE &&
        regReq.addr <= ADDR_IRQ))
        else $error("register hit decode wrong");
    a_irq_release: assert property (
        rdIrq && $stable(linkState) ##1 clkEn |=> irq_out_n)
        else $error("irq pin not released after read");
    cover property (rdIrq);
    cover property ($fell(irq_out_n));
    cover property (rdTen);
endmodule

bind phy_vendor_config_irq_regs phy_vendor_regs_sva i_sva (.core_clk,
    .rst, .clkEn, .regReq, .regRdData, .regHit, .linkState,
    .polarityReversed,
    .linkPulseTxEn, .serialIfActive, .crossoverState, .irq_out_n);

// File: bench/mgmt_master.sv
// Management station model issuing register reads and writes
`timescale 1ns/10ps
module mgmt_master
    import phy_vendor_regs_pkg::*;
(
    input wire logic core_clk,
    output regReq_s regReq,
    input wire logic [DATA_W-1:0] regRdData,
    input wire logic regRdValid
);
    initial regReq = '0;
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge core_clk);
        #1 regReq = '{1'b1, 1'b0, a, d};
        @(posedge core_clk);
        // Released lines show the inverse, never a stale value
        #1 regReq = '{1'b0, 1'b0, ~a, ~d};
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge core_clk);
        #1 regReq = '{1'b0, 1'b1, a, regReq.wrData};
        @(posedge core_clk);
        #1 regReq = '{1'b0, 1'b0, ~a, ~regReq.wrData};
        // Valid stands only for the cycle after the taking edge
        d = (regRdValid === 1'b1) ? regRdData : 'x;
        @(posedge core_clk);
        #1;
    endtask
endmodule

// File: bench/tb_top.sv
// Self-checking bench for the vendor register bank
`timescale 1ns/10ps
module tb_top
    import phy_vendor_regs_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic clkEn = 1'b1;
    logic serialStrap = 1'b1;
    logic loopback10 = 1'b0;
    logic polarityReversed = 1'b0;
    logic autoMdix = 1'b1;
    logic rawSignalDetect = 1'b0;
    logic [8:0] normalPowerdown = 9'h0a5;
    linkState_s linkState = '0;
    regReq_s regReq;
    logic [15:0] regRdData, d;
    logic [15:0] msk [3];
    logic [15:0] expOnes [5] = '{16'h7c01, 16'h01ff, 16'hf0ff, 16'h0f00,
        16'h0000};
    logic regRdValid, regHit, linkPulseTxEn, forceLinkGood, heartbeatActive;
    logic jabberActive, squelchNormal, serialIfActive, signalDetect100;
    logic crossoverState, negotiationLoopback, irq_out_n;
    logic [8:0] sectionPowerdown;
    int fails = 0;
    int checks = 0;
    always #5 core_clk = ~core_clk;
    phy_vendor_config_irq_regs i_dut (.core_clk, .rst, .clkEn, .regReq,
        .regRdData, .regRdValid, .regHit, .serialStrap, .linkState,
        .loopback10, .polarityReversed, .autoMdix, .rawSignalDetect,
        .normalPowerdown, .linkPulseTxEn, .forceLinkGood, .heartbeatActive,
        .jabberActive, .squelchNormal, .serialIfActive, .signalDetect100,
        .crossoverState, .negotiationLoopback, .sectionPowerdown, .irq_out_n);
    mgmt_master i_mgmt (.core_clk, .regReq, .regRdData, .regRdValid);
    task automatic chk(input string n, input logic [15:0] e,
        input logic [15:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rdc(input logic [4:0] a, input logic [15:0] e);
        logic [15:0] v;
        i_mgmt.rd(a, v);
        chk($sformatf("register %h", a), e, v);
    endtask
    function automatic logic [15:0] tenOut();
        return {10'h0, squelchNormal, linkPulseTxEn, forceLinkGood,
            heartbeatActive, serialIfActive, jabberActive};
    endfunction
    function automatic logic [15:0] venOut();
        return {4'h0, sectionPowerdown, signalDetect100, crossoverState,
            negotiationLoopback};
    endfunction
    task automatic final_report;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        fails++;
        final_report;
    end
    initial begin
        repeat (8) @(posedge core_clk);
        #1 rst = 1'b0;
        repeat (2) @(posedge core_clk);
        rdc(ADDR_TEN_BASE, 16'h7c00);
        rdc(ADDR_PWRDN, 16'h0000);
        rdc(ADDR_VENDOR, 16'h0080);
        rdc(ADDR_IRQ, 16'h0f00);
        $display("test reset values done");
        polarityReversed = 1'b1;
        loopback10 = 1'b1;
        autoMdix = 1'b0;
        for (int i = 0; i < 5; i++) begin
            i_mgmt.wr(5'h12 + 5'(i), 16'hffff);
            rdc(5'h12 + 5'(i), expOnes[i]);
        end
        chk("ten base outputs", 16'h0037, tenOut());
        chk("vendor outputs", 16'h0fff, venOut());
        i_mgmt.wr(ADDR_TEN_BASE, 16'h0000);
        i_mgmt.wr(ADDR_VENDOR, 16'h0000);
        rdc(ADDR_TEN_BASE, 16'h0001);
        chk("ten base off", 16'h0008, tenOut());
        chk("vendor off", 16'h0000, venOut());
        rawSignalDetect = 1'b1;
        autoMdix = 1'b1;
        i_mgmt.wr(ADDR_PWRDN, 16'h0000);
        chk("normal control", 16'h052e, venOut());
        $display("test config registers done");
        for (int i = 0; i < 3; i++) begin
            msk = '{16'h0e00 & ~(16'h0200 << i), 16'h0e00, 16'h0100};
            for (int j = 0; j < 3; j++) begin
                i_mgmt.wr(ADDR_IRQ, msk[j]);
                linkState[i] = ~linkState[i];
                repeat (3) @(posedge core_clk);
                #1 chk("irq pin", {15'h0, j != 0}, {15'h0, irq_out_n});
                rdc(ADDR_IRQ, msk[j] | (16'h0004 << i)
                    | (j == 0 ? 16'h8001 : 16'h0));
                chk("irq released", 16'h1, {15'h0, irq_out_n});
            end
        end
        $display("test change interrupts done");
        i_mgmt.wr(ADDR_IRQ, 16'h0000);
        linkState.linkUp = ~linkState.linkUp;
        repeat (3) @(posedge core_clk);
        fork
            i_mgmt.rd(ADDR_IRQ, d);
            begin
                @(posedge core_clk);
                #1 linkState.linkUp = ~linkState.linkUp;
            end
        join
        chk("first read", 16'h8005, d);
        rdc(ADDR_IRQ, 16'h8005);
        $display("test read clear race done");
        // Link now at 100M full duplex
        i_mgmt.wr(ADDR_TEN_BASE, 16'hffff);
        chk("ten base at 100M", 16'h0021, tenOut());
        clkEn = 1'b0;
        i_mgmt.wr(ADDR_VENDOR, 16'hffff);
        clkEn = 1'b1;
        chk("frozen vendor", 16'h052e, venOut());
        $display("test fast mode and freeze done");
        final_report;
    end
endmodule
